// ---- rsc_clock_loss.sv ----
module rsc_clock_loss #(
  parameter int unsigned TIMEOUT_CYC = rsc_pkg::MCD_TIMEOUT_CYC
) (
  input wire logic mclk_in,       // reference clock
  input wire logic rst_b_in,      // power-on reset, active low
  input wire logic enable_in,     // detector armed
  input wire logic sys_clk_in,    // monitored system clock level
  output logic timeout_out        // level: clock stuck too long
);

  localparam int unsigned CW = $clog2(TIMEOUT_CYC + 1);

  logic [CW-1:0] cnt_q, cnt_d;
  logic lvl_q, lvl_d;
  logic to_q, to_d;

  // ----------------------------------------------------------------
  // stuck-level counter
  // ----------------------------------------------------------------
  // any edge of the monitored clock restarts the one-shot
  always_comb begin
    lvl_d = sys_clk_in;
    cnt_d = cnt_q;
    to_d = to_q;
    if (!enable_in || (sys_clk_in != lvl_q)) begin
      cnt_d = '0;
      to_d = 1'b0;
    end else if (cnt_q != CW'(TIMEOUT_CYC)) begin
      cnt_d = cnt_q + CW'(1);
    end else begin
      to_d = 1'b1;
    end
  end

  always_ff @(posedge mclk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      cnt_q <= '0;
      lvl_q <= 1'b0;
      to_q <= 1'b0;
    end else begin
      cnt_q <= cnt_d;
      lvl_q <= lvl_d;
      to_q <= to_d;
    end
  end

  assign timeout_out = to_q;

endmodule : rsc_clock_loss

// ---- rsc_pkg.sv ----
package rsc_pkg;

  // ----------------------------------------------------------------
  // register bus and addresses
  // ----------------------------------------------------------------
  localparam int unsigned SFR_AW = 8;
  localparam int unsigned SFR_DW = 8;
  localparam logic [SFR_AW-1:0] VDM_CTRL_ADDR = 8'hFF;  // supply_monitor_control
  localparam logic [SFR_AW-1:0] RST_CAUSE_ADDR = 8'hEF; // reset_cause_register

  // ----------------------------------------------------------------
  // supply_monitor_control fields
  // ----------------------------------------------------------------
  localparam int unsigned VDM_EN_BIT = 7;
  localparam int unsigned VDM_STAT_BIT = 6;
  localparam int unsigned VDM_WARN_BIT = 5;
  localparam logic [SFR_DW-1:0] VDM_ZERO_MASK = 8'h1F; // bits that always read zero
  localparam logic VDM_EN_RESET = 1'h1;
  localparam logic SUPPLY_SEL_RESET = 1'h1;

  // ----------------------------------------------------------------
  // reset_cause_register fields, also the cause vector index
  // ----------------------------------------------------------------
  localparam int unsigned CAUSE_PIN = 0;
  localparam int unsigned CAUSE_POR = 1;
  localparam int unsigned CAUSE_MCD = 2;
  localparam int unsigned CAUSE_WDT = 3;
  localparam int unsigned CAUSE_SW = 4;
  localparam int unsigned CAUSE_CMP = 5;
  localparam int unsigned CAUSE_FLASH = 6;
  localparam int unsigned CAUSE_RTC = 7;
  localparam int unsigned CAUSE_W = 8;
  localparam logic [CAUSE_W-1:0] RST_CAUSE_RESET = 8'h02; // power-on flag only

  // ----------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------
  localparam int unsigned CLK_MHZ = 50;
  localparam int unsigned MCD_TIMEOUT_US = 100;
  localparam int unsigned MCD_TIMEOUT_CYC = MCD_TIMEOUT_US * CLK_MHZ; // longest, floor
  localparam int unsigned WDT_DIV = 12;
  localparam int unsigned WDT_DIV_W = 4;
  localparam int unsigned HOLD_CYC = 4;  // least time the core is kept in reset
  localparam int unsigned HOLD_W = 3;

  // ----------------------------------------------------------------
  // sequencer states
  // ----------------------------------------------------------------
  typedef enum logic {st_run, st_hold} rsc_state_t;

endpackage : rsc_pkg

// ---- rsc_reset_controller.sv ----
module rsc_reset_controller #(
  parameter int unsigned MCD_TIMEOUT_CYC = rsc_pkg::MCD_TIMEOUT_CYC,
  parameter int unsigned FLASH_AW = 16
) (
  input wire logic mclk_in,                       // system clock, 50 MHz
  input wire logic rst_b_in,                      // power-on reset, active low
  input wire logic [rsc_pkg::SFR_AW-1:0] sfr_addr_in,  // register address
  input wire logic sfr_wr_in,                     // register write strobe
  input wire logic [rsc_pkg::SFR_DW-1:0] sfr_wdata_in, // register write data
  output logic [rsc_pkg::SFR_DW-1:0] sfr_rdata_out,    // read data, one cycle late
  input wire logic rst_pin_b_in,                  // external reset pin, active low
  input wire logic suspend_in,                    // suspend mode active
  input wire logic sleep_in,                      // sleep mode active
  input wire logic supply_above_reset_in,         // supply above reset threshold
  input wire logic supply_above_warning_in,       // supply above warning threshold
  input wire logic system_clock_main_in,          // monitored system clock
  input wire logic comparator_out_in,             // 1: positive input above negative
  input wire logic comparator_wake_en_in,         // comparator is a wake-up source
  input wire logic wdt_overflow_in,               // watchdog expired, pulse
  input wire logic wdt_ctl_wr_in,                 // watchdog enable write, pulse
  input wire logic wdt_ctl_en_in,                 // watchdog enable value
  input wire logic flash_wr_in,                   // flash write or erase attempt
  input wire logic flash_write_enable_in,         // flash writes enabled
  input wire logic code_space_read_in,            // data read from code space
  input wire logic branch_fetch_in,               // program fetch after branch
  input wire logic [FLASH_AW-1:0] flash_addr_in,  // flash target address
  input wire logic [FLASH_AW-1:0] lock_addr_in,   // lock byte address
  input wire logic flash_secure_block_in,         // access refused by security
  input wire logic rtc_alarm_in,                  // rtc alarm match
  input wire logic rtc_osc_fail_in,               // rtc oscillator too slow
  input wire logic rtc_osc_det_en_in,             // rtc clock-loss detection on
  output logic core_rst_b_out,                    // core reset, active low
  output logic wdt_enable_out,                    // watchdog enabled
  output logic wdt_tick_out                       // watchdog clock, mclk_in / 12
);

  // ----------------------------------------------------------------
  // parameter checks
  // ----------------------------------------------------------------
  if (MCD_TIMEOUT_CYC < 2 || FLASH_AW < 1 || FLASH_AW > 32) begin : g_bad_param
    $error("rsc_reset_controller: unsupported parameter value");
  end

  // ----------------------------------------------------------------
  // declarations
  // ----------------------------------------------------------------
  localparam int unsigned CW = rsc_pkg::CAUSE_W;

  rsc_pkg::rsc_state_t state_q, state_d;
  logic [rsc_pkg::HOLD_W-1:0] hold_cnt_q, hold_cnt_d;
  logic [CW-1:0] cause_q, cause_d;
  logic [CW-1:0] rst_cause_q, rst_cause_d;
  logic vdm_en_q, vdm_en_d;
  logic supply_sel_q, supply_sel_d;
  logic wdt_en_q, wdt_en_d;
  logic [rsc_pkg::WDT_DIV_W-1:0] div_q, div_d, run_age_q, run_age_d;
  logic tick_q, tick_d;
  logic [rsc_pkg::SFR_DW-1:0] rdata_q, rdata_d;
  logic [CW-1:0] src;
  logic run, low_power, leave_hold;
  logic wr_vdm, wr_cause;
  logic mcd_timeout, flash_fault;

  function automatic logic above_lock(input logic [FLASH_AW-1:0] addr,
                                      input logic [FLASH_AW-1:0] lock);
    above_lock = addr > lock;
  endfunction : above_lock

  // ----------------------------------------------------------------
  // decode
  // ----------------------------------------------------------------
  assign run = (state_q == rsc_pkg::st_run);
  assign low_power = suspend_in | sleep_in;
  assign wr_vdm = sfr_wr_in && (sfr_addr_in == rsc_pkg::VDM_CTRL_ADDR);
  assign wr_cause = sfr_wr_in && (sfr_addr_in == rsc_pkg::RST_CAUSE_ADDR);

  // ----------------------------------------------------------------
  // clock-loss detector
  // ----------------------------------------------------------------
  // disarmed in low power so a stopped clock there is not a fault
  rsc_clock_loss #(
    .TIMEOUT_CYC(MCD_TIMEOUT_CYC)
  ) u_clock_loss (
    .mclk_in(mclk_in),
    .rst_b_in(rst_b_in),
    .enable_in(rst_cause_q[rsc_pkg::CAUSE_MCD] & ~low_power),
    .sys_clk_in(system_clock_main_in),
    .timeout_out(mcd_timeout)
  );

  // ----------------------------------------------------------------
  // flash access check
  // ----------------------------------------------------------------
  assign flash_fault = (flash_wr_in && flash_write_enable_in
                        && above_lock(flash_addr_in, lock_addr_in))
                     || (code_space_read_in && above_lock(flash_addr_in, lock_addr_in))
                     || (branch_fetch_in && above_lock(flash_addr_in, lock_addr_in))
                     || flash_secure_block_in
                     || (flash_wr_in && !vdm_en_q);

  // ----------------------------------------------------------------
  // reset sources
  // ----------------------------------------------------------------
  // core-driven events only count while the core runs; level sources
  // keep the hold going for as long as they stay asserted
  always_comb begin
    src = '0;
    src[rsc_pkg::CAUSE_PIN] = !rst_pin_b_in;
    src[rsc_pkg::CAUSE_POR] = vdm_en_q && supply_sel_q
                              && !supply_above_reset_in && !sleep_in;
    src[rsc_pkg::CAUSE_MCD] = rst_cause_q[rsc_pkg::CAUSE_MCD]
                              && !low_power && mcd_timeout;
    src[rsc_pkg::CAUSE_WDT] = run && wdt_en_q && !low_power
                              && wdt_overflow_in;
    src[rsc_pkg::CAUSE_SW] = run && wr_cause
                             && sfr_wdata_in[rsc_pkg::CAUSE_SW];
    src[rsc_pkg::CAUSE_CMP] = rst_cause_q[rsc_pkg::CAUSE_CMP]
                              && !comparator_out_in
                              && (!low_power || comparator_wake_en_in);
    src[rsc_pkg::CAUSE_FLASH] = run && flash_fault;
    src[rsc_pkg::CAUSE_RTC] = rst_cause_q[rsc_pkg::CAUSE_RTC]
                              && (rtc_alarm_in || (rtc_osc_det_en_in && rtc_osc_fail_in));
  end

  // ----------------------------------------------------------------
  // reset sequencer
  // ----------------------------------------------------------------
  // the cause is caught on entry; a short minimum hold gives pulse
  // sources a clean reset even though they last one cycle
  always_comb begin
    state_d = state_q;
    hold_cnt_d = hold_cnt_q;
    cause_d = cause_q;
    case (state_q)
      rsc_pkg::st_run: begin
        if (|src) begin
          state_d = rsc_pkg::st_hold;
          cause_d = src;
          hold_cnt_d = '0;
        end
      end
      rsc_pkg::st_hold: begin
        if (hold_cnt_q != rsc_pkg::HOLD_W'(rsc_pkg::HOLD_CYC - 1)) begin
          hold_cnt_d = hold_cnt_q + rsc_pkg::HOLD_W'(1);
        end else if (!(|src)) begin
          state_d = rsc_pkg::st_run;
        end
      end
      default: begin
        state_d = rsc_pkg::st_run;
      end
    endcase
  end

  always_ff @(posedge mclk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      state_q <= rsc_pkg::st_run;
      hold_cnt_q <= '0;
      cause_q <= '0;
    end else begin
      state_q <= state_d;
      hold_cnt_q <= hold_cnt_d;
      cause_q <= cause_d;
    end
  end

  assign leave_hold = (state_q == rsc_pkg::st_hold) && (state_d == rsc_pkg::st_run);

  // ----------------------------------------------------------------
  // control and cause registers
  // ----------------------------------------------------------------
  // writes only land while the core runs, and flags only change on the
  // way out of reset, so a write can never collide with a flag update
  always_comb begin
    rst_cause_d = rst_cause_q;
    vdm_en_d = vdm_en_q;
    supply_sel_d = supply_sel_q;
    wdt_en_d = wdt_en_q;
    if (leave_hold) begin
      rst_cause_d = cause_q;
      wdt_en_d = 1'b1;
      if (cause_q[rsc_pkg::CAUSE_POR]) begin
        vdm_en_d = 1'b1;
        supply_sel_d = 1'b1;
      end
    end else if (run) begin
      if (wr_vdm) begin
        vdm_en_d = sfr_wdata_in[rsc_pkg::VDM_EN_BIT];
      end
      if (wr_cause) begin
        rst_cause_d[rsc_pkg::CAUSE_MCD] = sfr_wdata_in[rsc_pkg::CAUSE_MCD];
        rst_cause_d[rsc_pkg::CAUSE_CMP] = sfr_wdata_in[rsc_pkg::CAUSE_CMP];
        rst_cause_d[rsc_pkg::CAUSE_RTC] = sfr_wdata_in[rsc_pkg::CAUSE_RTC];
        supply_sel_d = sfr_wdata_in[rsc_pkg::CAUSE_POR];
      end
      if (wdt_ctl_wr_in) begin
        wdt_en_d = wdt_ctl_en_in;
      end
    end
  end

  always_ff @(posedge mclk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      rst_cause_q <= rsc_pkg::RST_CAUSE_RESET;
      vdm_en_q <= rsc_pkg::VDM_EN_RESET;
      supply_sel_q <= rsc_pkg::SUPPLY_SEL_RESET;
      wdt_en_q <= 1'b1;
    end else begin
      rst_cause_q <= rst_cause_d;
      vdm_en_q <= vdm_en_d;
      supply_sel_q <= supply_sel_d;
      wdt_en_q <= wdt_en_d;
    end
  end

  // ----------------------------------------------------------------
  // watchdog clock divider
  // ----------------------------------------------------------------
  // restarts with the core so the first tick comes a full period late
  always_comb begin
    div_d = '0;
    tick_d = 1'b0;
    run_age_d = '0; // run cycles since reset exit, saturating; read by the start check
    if (run) begin
      run_age_d = (run_age_q == '1) ? run_age_q : run_age_q + rsc_pkg::WDT_DIV_W'(1);
      if (div_q == rsc_pkg::WDT_DIV_W'(rsc_pkg::WDT_DIV - 1)) begin
        tick_d = 1'b1;
      end else begin
        div_d = div_q + rsc_pkg::WDT_DIV_W'(1);
      end
    end
  end

  always_ff @(posedge mclk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      div_q <= '0;
      tick_q <= 1'b0;
      run_age_q <= '0;
    end else begin
      div_q <= div_d;
      tick_q <= tick_d;
      run_age_q <= run_age_d;
    end
  end

  // ----------------------------------------------------------------
  // register read
  // ----------------------------------------------------------------
  // unmapped addresses read zero
  always_comb begin
    rdata_d = '0;
    if (sfr_addr_in == rsc_pkg::VDM_CTRL_ADDR) begin
      rdata_d[rsc_pkg::VDM_EN_BIT] = vdm_en_q;
      rdata_d[rsc_pkg::VDM_STAT_BIT] = supply_above_reset_in;
      rdata_d[rsc_pkg::VDM_WARN_BIT] = supply_above_warning_in;
    end else if (sfr_addr_in == rsc_pkg::RST_CAUSE_ADDR) begin
      rdata_d = rst_cause_q;
    end
  end

  always_ff @(posedge mclk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      rdata_q <= '0;
    end else begin
      rdata_q <= rdata_d;
    end
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  // nothing here reaches the reset pin; it is an input only
  assign core_rst_b_out = run;
  assign sfr_rdata_out = rdata_q;
  assign wdt_enable_out = wdt_en_q;
  assign wdt_tick_out = tick_q;

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge mclk_in); endclocking
  default disable iff (!rst_b_in);

  reserved_zero_a: assert property (
    (sfr_addr_in == rsc_pkg::VDM_CTRL_ADDR) |=> ((sfr_rdata_out & rsc_pkg::VDM_ZERO_MASK) == 8'h00))
    else $error("reserved supply monitor bits not zero");
  supply_stat_a: assert property (
    (sfr_addr_in == rsc_pkg::VDM_CTRL_ADDR)
    |=> (sfr_rdata_out[rsc_pkg::VDM_STAT_BIT] == $past(supply_above_reset_in)))
    else $error("supply status bit wrong");
  warn_stat_a: assert property (
    (sfr_addr_in == rsc_pkg::VDM_CTRL_ADDR)
    |=> (sfr_rdata_out[rsc_pkg::VDM_WARN_BIT] == $past(supply_above_warning_in)))
    else $error("warning status bit wrong");
  pin_reset_a: assert property (
    !rst_pin_b_in |=> !core_rst_b_out)
    else $error("pin reset not applied");
  cause_record_a: assert property (
    $rose(core_rst_b_out) |-> (rst_cause_q == $past(cause_q)))
    else $error("reset cause not recorded");
  mcd_lowpower_a: assert property (
    (core_rst_b_out && low_power && !(|(src & ~(CW'(1) << rsc_pkg::CAUSE_MCD))))
    |=> core_rst_b_out)
    else $error("clock-loss reset active in low power");
  cmp_lowpower_a: assert property (
    (core_rst_b_out && low_power && !comparator_wake_en_in
     && !(|(src & ~(CW'(1) << rsc_pkg::CAUSE_CMP)))) |=> core_rst_b_out)
    else $error("comparator reset active without wake-up");
  wdt_reset_a: assert property (
    (core_rst_b_out && wdt_enable_out && !low_power && wdt_overflow_in) |=> !core_rst_b_out)
    else $error("watchdog overflow did not reset");
  sw_reset_a: assert property (
    (core_rst_b_out && wr_cause && sfr_wdata_in[rsc_pkg::CAUSE_SW])
    |=> !core_rst_b_out ##0 cause_q[rsc_pkg::CAUSE_SW])
    else $error("software reset not forced");
  flash_reset_a: assert property (
    (core_rst_b_out && flash_wr_in && !vdm_en_q) |=> !core_rst_b_out)
    else $error("unmonitored flash write did not reset");
  hold_min_a: assert property (
    $fell(core_rst_b_out) |-> !core_rst_b_out [*4])
    else $error("reset hold too short");
  wdt_start_a: assert property (
    $rose(core_rst_b_out) |-> wdt_enable_out
    ##12 (wdt_tick_out || (run_age_q != rsc_pkg::WDT_DIV_W'(rsc_pkg::WDT_DIV))))
    else $error("watchdog not restarted after reset");

  pin_cycle_c: cover property (!rst_pin_b_in ##1 !core_rst_b_out ##[1:20] core_rst_b_out);
  sw_cycle_c: cover property (src[rsc_pkg::CAUSE_SW] ##[1:20] $rose(core_rst_b_out));
  mcd_cycle_c: cover property (src[rsc_pkg::CAUSE_MCD] ##1 !core_rst_b_out);
  rtc_cycle_c: cover property (src[rsc_pkg::CAUSE_RTC] ##1 !core_rst_b_out);

endmodule : rsc_reset_controller

// ---- tb.sv ----
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic mclk_in, rst_b_in, sfr_wr_in, rst_pin_b_in, suspend_in, sleep_in, core_rst_b_out;
  logic supply_above_reset_in, supply_above_warning_in, system_clock_main_in, stuck;
  logic comparator_out_in, comparator_wake_en_in, wdt_overflow_in, wdt_ctl_wr_in;
  logic wdt_ctl_en_in, flash_wr_in, flash_write_enable_in, code_space_read_in;
  logic branch_fetch_in, flash_secure_block_in, rtc_alarm_in, rtc_osc_fail_in;
  logic rtc_osc_det_en_in, wdt_enable_out, wdt_tick_out;
  logic [rsc_pkg::SFR_DW-1:0] sfr_wdata_in, sfr_rdata_out, d;
  logic [rsc_pkg::SFR_AW-1:0] sfr_addr_in;
  logic [15:0] flash_addr_in, lock_addr_in;
  logic [31:0] seed, r;
  int miscompares, cmp_count, cyc, i, k;

  // short clock-loss count keeps the stuck-clock case quick
  rsc_reset_controller #(.MCD_TIMEOUT_CYC(20), .FLASH_AW(16)) u_rsc_reset_controller (
    .mclk_in, .rst_b_in, .sfr_addr_in, .sfr_wr_in, .sfr_wdata_in, .sfr_rdata_out,
    .rst_pin_b_in, .suspend_in, .sleep_in, .supply_above_reset_in, .supply_above_warning_in,
    .system_clock_main_in, .comparator_out_in, .comparator_wake_en_in, .wdt_overflow_in,
    .wdt_ctl_wr_in, .wdt_ctl_en_in, .flash_wr_in, .flash_write_enable_in, .code_space_read_in,
    .branch_fetch_in, .flash_addr_in, .lock_addr_in, .flash_secure_block_in, .rtc_alarm_in,
    .rtc_osc_fail_in, .rtc_osc_det_en_in, .core_rst_b_out, .wdt_enable_out, .wdt_tick_out);

  // ----------------------------------------------------------------
  // clock, monitored clock and hang guard
  // ----------------------------------------------------------------
  initial begin
    mclk_in = 1'b0;
    forever #10 mclk_in = ~mclk_in;
  end

  // the monitored clock toggles unless a scenario freezes it
  always @(posedge mclk_in) begin
    cyc <= cyc + 1;
    if (!stuck) system_clock_main_in <= #1 ~system_clock_main_in;
    if (cyc == 20000) begin
      miscompares++;
      close_out();
    end
  end

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  function automatic logic [31:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction : xs

  task automatic step();
    @(posedge mclk_in);
    #1;
  endtask : step

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    cmp_count++;
    if (got !== exp) begin
      miscompares++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic wr(input logic [7:0] a, input logic [7:0] v);
    step();
    sfr_addr_in = a;
    sfr_wdata_in = v;
    sfr_wr_in = 1'b1;
    step();
    sfr_wr_in = 1'b0;
  endtask : wr

  // read data is registered, so it is taken one edge after the address
  task automatic rd(input logic [7:0] a, output logic [7:0] v);
    step();
    sfr_addr_in = a;
    step();
    v = sfr_rdata_out;
  endtask : rd

  task automatic hit();
    for (k = 0; k < 60 && core_rst_b_out !== 1'b0; k++) step();
    chk({7'h0, core_rst_b_out}, 8'h00);
  endtask : hit

  task automatic quiet(input int n);
    logic seen;
    seen = 1'b0;
    repeat (n) begin
      step();
      if (core_rst_b_out !== 1'b1) seen = 1'b1;
    end
    chk({7'h0, seen}, 8'h00);
  endtask : quiet

  task automatic exit_cause(input logic [7:0] c);
    for (k = 0; k < 60 && core_rst_b_out !== 1'b1; k++) step();
    rd(rsc_pkg::RST_CAUSE_ADDR, d);
    chk(d, c);
  endtask : exit_cause

  task automatic close_out();
    if (miscompares == 0 && cmp_count > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : close_out

  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial begin
    {rst_b_in, sfr_wr_in, suspend_in, sleep_in, stuck, system_clock_main_in} = 6'h00;
    {wdt_overflow_in, wdt_ctl_wr_in, wdt_ctl_en_in, flash_wr_in, flash_write_enable_in} = 5'h00;
    {code_space_read_in, branch_fetch_in, flash_secure_block_in, comparator_wake_en_in} = 4'h0;
    {rtc_alarm_in, rtc_osc_fail_in, rtc_osc_det_en_in} = 3'h0;
    {rst_pin_b_in, supply_above_reset_in, supply_above_warning_in, comparator_out_in} = 4'hF;
    sfr_addr_in = 8'h00;
    sfr_wdata_in = 8'h00;
    flash_addr_in = 16'h0100;
    lock_addr_in = 16'h4000;
    seed = 32'h0000FFF9;
    miscompares = 0;
    cmp_count = 0;
    cyc = 0;
    repeat (4) @(posedge mclk_in);
    #1 rst_b_in = 1'b1;
    rd(rsc_pkg::RST_CAUSE_ADDR, d);
    chk(d, 8'h02);
    // warning level moves freely while the monitor stays armed
    for (i = 0; i < 4; i++) begin
      r = xs();
      supply_above_warning_in = r[0];
      rd(rsc_pkg::VDM_CTRL_ADDR, d);
      chk(d, {2'h3, r[0], 5'h00});
    end
    // monitor off: low supply shows in status but must not reset
    r = xs();
    wr(rsc_pkg::VDM_CTRL_ADDR, {1'b0, r[6:5], 3'h0, r[1:0]});
    for (i = 0; i < 4; i++) begin
      r = xs();
      {supply_above_reset_in, supply_above_warning_in} = r[1:0];
      rd(rsc_pkg::VDM_CTRL_ADDR, d);
      chk(d, {1'b0, r[1:0], 5'h00});
    end
    chk({7'h0, core_rst_b_out}, 8'h01);
    {supply_above_reset_in, supply_above_warning_in} = 2'h3;
    // flash write with the monitor off faults even below the lock byte
    flash_wr_in = 1'b1;
    step();
    flash_wr_in = 1'b0;
    hit();
    exit_cause(8'h40);
    wr(rsc_pkg::VDM_CTRL_ADDR, 8'h80);
    flash_addr_in = 16'h8000;
    flash_write_enable_in = 1'b1;
    for (i = 0; i < 4; i++) begin
      {flash_wr_in, code_space_read_in, branch_fetch_in, flash_secure_block_in} = 4'h8 >> i;
      step();
      {flash_wr_in, code_space_read_in, branch_fetch_in, flash_secure_block_in} = 4'h0;
      hit();
      exit_cause(8'h40);
    end
    // pin reset awake and asleep
    for (i = 0; i < 2; i++) begin
      sleep_in = i[0];
      rst_pin_b_in = 1'b0;
      hit();
      rst_pin_b_in = 1'b1;
      exit_cause(8'h01);
    end
    sleep_in = 1'b0;
    // watchdog disabled by software ignores overflow until the next reset
    wdt_ctl_wr_in = 1'b1;
    step();
    wdt_ctl_wr_in = 1'b0;
    chk({7'h0, wdt_enable_out}, 8'h00);
    wdt_overflow_in = 1'b1;
    step();
    wdt_overflow_in = 1'b0;
    quiet(10);
    wr(rsc_pkg::RST_CAUSE_ADDR, 8'h12);
    hit();
    exit_cause(8'h10);
    chk({7'h0, wdt_enable_out}, 8'h01);
    for (k = 0; k < 30 && wdt_tick_out !== 1'b1; k++) step();
    k = 0;
    do begin
      step();
      k++;
    end while (wdt_tick_out !== 1'b1 && k < 30);
    chk(k[7:0], 8'h0C);
    for (i = 0; i < 2; i++) begin
      suspend_in = ~i[0];
      wdt_overflow_in = 1'b1;
      step();
      wdt_overflow_in = 1'b0;
      if (i == 0) quiet(10);
    end
    hit();
    exit_cause(8'h08);
    wr(rsc_pkg::RST_CAUSE_ADDR, 8'h02);
    rd(rsc_pkg::RST_CAUSE_ADDR, d);
    chk(d, 8'h08);
    // comparator in sleep fires only as a wake-up source
    wr(rsc_pkg::RST_CAUSE_ADDR, 8'h22);
    sleep_in = 1'b1;
    comparator_out_in = 1'b0;
    quiet(10);
    comparator_wake_en_in = 1'b1;
    hit();
    comparator_out_in = 1'b1;
    exit_cause(8'h20);
    sleep_in = 1'b0;
    // stuck clock: held off in suspend, fires once suspend ends
    wr(rsc_pkg::RST_CAUSE_ADDR, 8'h06);
    suspend_in = 1'b1;
    stuck = 1'b1;
    quiet(40);
    suspend_in = 1'b0;
    hit();
    stuck = 1'b0;
    exit_cause(8'h04);
    wr(rsc_pkg::RST_CAUSE_ADDR, 8'h02);
    stuck = 1'b1;
    quiet(40);
    stuck = 1'b0;
    // rtc alarm and oscillator fail, both while asleep
    rtc_osc_det_en_in = 1'b1;
    sleep_in = 1'b1;
    for (i = 0; i < 2; i++) begin
      wr(rsc_pkg::RST_CAUSE_ADDR, 8'h82);
      {rtc_alarm_in, rtc_osc_fail_in} = 2'h2 >> i;
      hit();
      {rtc_alarm_in, rtc_osc_fail_in} = 2'h0;
      exit_cause(8'h80);
    end
    // monitor armed but not selected must not reset; selecting it does
    sleep_in = 1'b0;
    wr(rsc_pkg::RST_CAUSE_ADDR, 8'h00);
    supply_above_reset_in = 1'b0;
    quiet(10);
    wr(rsc_pkg::RST_CAUSE_ADDR, 8'h02);
    hit();
    supply_above_reset_in = 1'b1;
    exit_cause(8'h02);
    close_out();
  end
endmodule : tb
